/* hw/tlc_line_code.sv */
// tlc_line_code: per-channel line-code, signaling, crc and sync options
// behind an apb slave.
// assumes framer strobes are synchronous one-cycle pulses on clk.
// Behaviour
// - tx substitutes b8zs when encoder select is 0, plain ami when 1
// - rx removes b8zs substitutions when decoder select is 0, plain ami when 1
// - with superframe update set, rx signaling changes only at superframe boundary
// - with superframe update set, new tx signaling starts at next superframe boundary
// - force-crc bit set corrupts outbound crc bits
// - j1 crc covers real fe bits; t1 counts every fe bit as one
// - japan_variant_select uses j1 sf or esf yellow alarm format both ways
// - j1 sf versus esf comes from j1 bit plus framing mode field
// - single-candidate clear: any valid candidate allows alignment; the lowest-numbered one wins
// - single-candidate set: align only when exactly one candidate remains
//
// Our own choice: the APB register port.
`timescale 1ns/1ns
module tlc_line_code (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_frame_start,
  input wire logic tx_valid,
  input wire logic tx_bit,
  output logic tx_pos,
  output logic tx_neg,
  input wire logic rx_frame_start,
  input wire logic rx_valid,
  input wire logic rx_pos,
  input wire logic rx_neg,
  output logic rx_data,
  output logic rx_data_valid,
  input wire logic rx_sig_valid,
  input wire logic [3:0] rx_sig_in,
  input wire logic rx_sf_boundary,
  output logic [3:0] receive_signaling_out,
  input wire logic [3:0] tx_sig_in,
  input wire logic tx_sf_boundary,
  output logic [3:0] tx_sig_out,
  input wire logic crc_bit_valid,
  input wire logic crc_bit,
  input wire logic crc_fe,
  input wire logic crc_mf_end,
  output logic [5:0] crc_result,
  output logic [1:0] tx_yellow_format,
  output logic [1:0] rx_yellow_format,
  input wire logic search_done,
  input wire logic [7:0] cand_mask,
  input wire logic sync_loss,
  output logic frame_aligned,
  output logic [2:0] align_winner
);

  // ==========================================================
  // helpers
  function automatic tlc_pkg::tlc_sym_t sym_of(input logic pos);
    sym_of = pos ? tlc_pkg::SYM_POS : tlc_pkg::SYM_NEG;
  endfunction : sym_of

  function automatic logic [5:0] crc_step(input logic [5:0] c, input logic b);
    crc_step = {c[4:0], 1'b0} ^ ((b ^ c[5]) ? tlc_pkg::CRC_POLY : 6'h00);
  endfunction : crc_step

  function automatic logic [1:0] yel_of(input tlc_pkg::tlc_fsel_t f);
    yel_of = {f.japan_variant_select, f.frame_mode == tlc_pkg::MODE_ESF};
  endfunction : yel_of

  function automatic logic [3:0] pop8(input logic [7:0] m);
    pop8 = 4'h0;
    for (int i = 0; i < 8; i++) begin
      pop8 = pop8 + {3'h0, m[i]};
    end
  endfunction : pop8

  function automatic logic [2:0] low8(input logic [7:0] m);
    low8 = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) begin
        low8 = 3'(i);
      end
    end
  endfunction : low8

  // ==========================================================
  // state
  logic [7:0] line_interface_control;
  tlc_pkg::tlc_fsel_t framing_select;
  logic [3:0] receive_signaling_array;
  logic [3:0] rx_sig_pend;
  logic tx_enc_off;
  logic rx_dec_off;
  tlc_pkg::tlc_fsel_t tx_fsel_act;
  tlc_pkg::tlc_fsel_t rx_fsel_act;
  tlc_pkg::tlc_sym_t tq [8];
  tlc_pkg::tlc_sym_t rq [8];
  tlc_pkg::tlc_sym_t rx_sym;
  tlc_pkg::tlc_sync_t sync_state;
  logic last_pol;
  logic next_last_pol;
  logic tx_run;
  logic rx_match;
  logic [5:0] crc;
  logic [5:0] next_crc;
  logic crc_in;
  logic [31:0] next_prdata;
  logic hit;
  logic ro;
  logic [3:0] cand_cnt;
  logic sync_ok;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ==========================================================
  // apb slave: answers in the first access cycle
  always_comb begin
    hit = 1'b1;
    ro = 1'b0;
    next_prdata = 32'h0000_0000;
    case (paddr)
      tlc_pkg::LIC_ADDR: next_prdata[7:0] = line_interface_control;
      tlc_pkg::FSEL_ADDR: next_prdata[7:0] = framing_select;
      tlc_pkg::SIGA_ADDR: begin
        ro = 1'b1;
        next_prdata[3:0] = receive_signaling_array;
      end
      tlc_pkg::STAT_ADDR: begin
        ro = 1'b1;
        next_prdata[tlc_pkg::STAT_ALIGN_BIT] = frame_aligned;
        next_prdata[tlc_pkg::STAT_WIN_LSB +: 3] = align_winner;
      end
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable && !pready;
      pslverr <= psel && !penable && !pready && (!hit || (pwrite && ro));
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      line_interface_control <= tlc_pkg::LIC_RST;
      framing_select <= tlc_pkg::FSEL_RST;
    end else if (psel && penable && pready && pwrite && !pslverr) begin
      if (paddr == tlc_pkg::LIC_ADDR) begin
        line_interface_control <= pwdata[7:0];
      end
      if (paddr == tlc_pkg::FSEL_ADDR) begin
        framing_select <= pwdata[7:0];
      end
    end
  end

  // ==========================================================
  // active options, taken only at frame boundaries
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_enc_off <= tlc_pkg::LIC_RST[tlc_pkg::LIC_ENC_BIT];
      tx_fsel_act <= tlc_pkg::FSEL_RST;
    end else if (tx_frame_start) begin
      tx_enc_off <= line_interface_control[tlc_pkg::LIC_ENC_BIT];
      tx_fsel_act <= framing_select;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_dec_off <= tlc_pkg::LIC_RST[tlc_pkg::LIC_DEC_BIT];
      rx_fsel_act <= tlc_pkg::FSEL_RST;
    end else if (rx_frame_start) begin
      rx_dec_off <= line_interface_control[tlc_pkg::LIC_DEC_BIT];
      rx_fsel_act <= framing_select;
    end
  end

  tx_cfg_hold_a: assert property (!tx_frame_start |=> $stable(tx_fsel_act) && $stable(tx_enc_off))
    else $error("tx options changed off a frame boundary");
  rx_cfg_hold_a: assert property (!rx_frame_start |=> $stable(rx_fsel_act) && $stable(rx_dec_off))
    else $error("rx options changed off a frame boundary");

  // ==========================================================
  // transmit encoder: eight-bit look-ahead so a run can be rewritten
  always_comb begin
    next_last_pol = last_pol;
    case (tq[0])
      tlc_pkg::SYM_MARK: next_last_pol = !last_pol;
      tlc_pkg::SYM_POS: next_last_pol = 1'b1;
      tlc_pkg::SYM_NEG: next_last_pol = 1'b0;
      default: next_last_pol = last_pol;
    endcase
    tx_run = !tx_bit && !tx_enc_off;
    for (int i = 1; i < 8; i++) begin
      if (tq[i] != tlc_pkg::SYM_ZERO) begin
        tx_run = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 8; i++) begin
        tq[i] <= tlc_pkg::SYM_ZERO;
      end
      last_pol <= 1'b0;
      tx_pos <= 1'b0;
      tx_neg <= 1'b0;
    end else if (tx_valid) begin
      for (int i = 0; i < 7; i++) begin
        tq[i] <= tq[i + 1];
      end
      tq[7] <= tx_bit ? tlc_pkg::SYM_MARK : tlc_pkg::SYM_ZERO;
      if (tx_run) begin
        tq[3] <= sym_of(next_last_pol);
        tq[4] <= sym_of(!next_last_pol);
        // 000vb0vb: the closing b is opposite the v, so the next mark alternates from it
        tq[6] <= sym_of(next_last_pol);
        tq[7] <= sym_of(!next_last_pol);
      end
      last_pol <= next_last_pol;
      tx_pos <= next_last_pol && (tq[0] != tlc_pkg::SYM_ZERO);
      tx_neg <= !next_last_pol && (tq[0] != tlc_pkg::SYM_ZERO);
    end
  end

  sequence tx_zero_run;
    tx_valid && tx_run;
  endsequence

  tx_sub_a: assert property (tx_zero_run |=> tq[3] != tlc_pkg::SYM_ZERO && tq[3] != tq[4]
    && tq[3] == tq[6] && tq[4] == tq[7])
    else $error("eight zeros not replaced by substitution");
  tx_ami_a: assert property (tx_valid && tx_enc_off && !tx_bit |=> tq[7] == tlc_pkg::SYM_ZERO)
    else $error("substitution made with encoder bypassed");

  // ==========================================================
  // receive decoder: a matched pattern is wiped back to zeros
  always_comb begin
    rx_sym = tlc_pkg::SYM_ZERO;
    if (rx_pos && !rx_neg) begin
      rx_sym = tlc_pkg::SYM_POS;
    end else if (rx_neg && !rx_pos) begin
      rx_sym = tlc_pkg::SYM_NEG;
    end
    rx_match = !rx_dec_off && rq[1] == tlc_pkg::SYM_ZERO && rq[2] == tlc_pkg::SYM_ZERO
      && rq[3] == tlc_pkg::SYM_ZERO && rq[6] == tlc_pkg::SYM_ZERO
      && rq[4] != tlc_pkg::SYM_ZERO && rq[5] != tlc_pkg::SYM_ZERO && rq[4] != rq[5]
      && rx_sym == rq[5] && rq[7] == rq[4];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 8; i++) begin
        rq[i] <= tlc_pkg::SYM_ZERO;
      end
      rx_data <= 1'b0;
      rx_data_valid <= 1'b0;
    end else begin
      rx_data_valid <= rx_valid;
      if (rx_valid) begin
        rx_data <= rq[0] != tlc_pkg::SYM_ZERO;
        for (int i = 0; i < 7; i++) begin
          rq[i] <= rx_match ? tlc_pkg::SYM_ZERO : rq[i + 1];
        end
        rq[7] <= rx_match ? tlc_pkg::SYM_ZERO : rx_sym;
      end
    end
  end

  rx_dec_a: assert property (rx_valid && rx_match |=> rq[7] == tlc_pkg::SYM_ZERO && rq[3] == tlc_pkg::SYM_ZERO)
    else $error("substitution pattern not removed");
  rx_ami_a: assert property (rx_valid && rx_dec_off && (rx_pos ^ rx_neg) |=> rq[7] != tlc_pkg::SYM_ZERO)
    else $error("pulse lost with decoder bypassed");

  // ==========================================================
  // robbed-bit signaling timing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_sig_pend <= 4'h0;
      receive_signaling_out <= 4'h0;
      receive_signaling_array <= 4'h0;
    end else if (rx_fsel_act.sig_sf) begin
      if (rx_sig_valid) begin
        rx_sig_pend <= rx_sig_in;
      end
      if (rx_sf_boundary) begin
        receive_signaling_out <= rx_sig_valid ? rx_sig_in : rx_sig_pend;
        receive_signaling_array <= rx_sig_valid ? rx_sig_in : rx_sig_pend;
      end
    end else if (rx_sig_valid) begin
      rx_sig_pend <= rx_sig_in;
      receive_signaling_out <= rx_sig_in;
      receive_signaling_array <= rx_sig_in;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_sig_out <= 4'h0;
    end else if (!tx_fsel_act.sig_sf || tx_sf_boundary) begin
      tx_sig_out <= tx_sig_in;
    end
  end

  sequence rx_sf_idle;
    rx_fsel_act.sig_sf && !rx_sf_boundary;
  endsequence

  sequence tx_sf_idle;
    tx_fsel_act.sig_sf && !tx_sf_boundary;
  endsequence

  rx_sig_hold_a: assert property (rx_sf_idle |=> $stable(receive_signaling_out))
    else $error("rx signaling changed inside a superframe");
  rx_sig_now_a: assert property (!rx_fsel_act.sig_sf && rx_sig_valid
    |=> receive_signaling_array == $past(rx_sig_in))
    else $error("rx signaling not updated at once");
  tx_sig_hold_a: assert property (tx_sf_idle |=> $stable(tx_sig_out))
    else $error("tx signaling changed inside a superframe");

  // ==========================================================
  // crc-6 over the multiframe; t1 counts fe bits as ones
  always_comb begin
    crc_in = (crc_fe && !tx_fsel_act.japan_variant_select) ? 1'b1 : crc_bit;
    next_crc = crc_bit_valid ? crc_step(crc, crc_in) : crc;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      crc <= tlc_pkg::CRC_SEED;
      crc_result <= tlc_pkg::CRC_SEED;
    end else if (crc_mf_end) begin
      crc <= tlc_pkg::CRC_SEED;
      crc_result <= next_crc ^ (tx_fsel_act.force_crc ? tlc_pkg::CRC_FORCE_MASK : 6'h00);
    end else begin
      crc <= next_crc;
    end
  end

  crc_force_a: assert property (crc_mf_end && tx_fsel_act.force_crc |=> crc_result == ~$past(next_crc))
    else $error("forced crc not corrupted");
  crc_fe_a: assert property (crc_bit_valid && crc_fe && !tx_fsel_act.japan_variant_select && !crc_mf_end
    |=> crc == crc_step($past(crc), 1'b1))
    else $error("t1 fe bit not taken as one");

  // ==========================================================
  // yellow alarm format, j1 bit plus framing mode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_yellow_format <= tlc_pkg::YEL_T1_SF;
      rx_yellow_format <= tlc_pkg::YEL_T1_SF;
    end else begin
      tx_yellow_format <= yel_of(tx_fsel_act);
      rx_yellow_format <= yel_of(rx_fsel_act);
    end
  end

  yellow_j1_a: assert property (##1 rx_fsel_act.japan_variant_select |-> ##1 rx_yellow_format[1])
    else $error("j1 yellow format not selected");

  // ==========================================================
  // synchroniser candidate policy
  always_comb begin
    cand_cnt = pop8(cand_mask);
    sync_ok = rx_fsel_act.single_candidate_only ? (cand_cnt == 4'h1) : (cand_cnt != 4'h0);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_state <= tlc_pkg::SYNC_HUNT;
      frame_aligned <= 1'b0;
      align_winner <= 3'h0;
    end else begin
      case (sync_state)
        tlc_pkg::SYNC_HUNT: begin
          if (search_done && sync_ok) begin
            sync_state <= tlc_pkg::SYNC_LOCK;
            frame_aligned <= 1'b1;
            align_winner <= low8(cand_mask);
          end
        end
        tlc_pkg::SYNC_LOCK: begin
          if (sync_loss) begin
            sync_state <= tlc_pkg::SYNC_HUNT;
            frame_aligned <= 1'b0;
          end
        end
        default: begin
          sync_state <= tlc_pkg::SYNC_HUNT;
          frame_aligned <= 1'b0;
        end
      endcase
    end
  end

  sync_one_a: assert property (sync_state == tlc_pkg::SYNC_HUNT && search_done
    && rx_fsel_act.single_candidate_only && pop8(cand_mask) != 4'h1 |=> !frame_aligned)
    else $error("aligned with other than one candidate");
  sync_any_a: assert property (sync_state == tlc_pkg::SYNC_HUNT && search_done
    && !rx_fsel_act.single_candidate_only && cand_mask != 8'h00 |=> frame_aligned)
    else $error("valid candidate not accepted");

endmodule : tlc_line_code

/* hw/tlc_pkg.sv */
// tlc_pkg: register map, field layouts, reset values and shared types
// for the t1 line-code and framing option block.
// assumes a 32-bit apb register bus and a single framer clock.
package tlc_pkg;

  // ==========================================================
  // register map: indices, byte address is four times the index
  localparam logic [15:0] LIC_IDX = 16'h0101;
  localparam logic [15:0] FSEL_IDX = 16'h0107;
  localparam logic [15:0] SIGA_IDX = 16'h0108;
  localparam logic [15:0] STAT_IDX = 16'h0109;
  localparam logic [15:0] LIC_ADDR = {LIC_IDX[13:0], 2'h0};
  localparam logic [15:0] FSEL_ADDR = {FSEL_IDX[13:0], 2'h0};
  localparam logic [15:0] SIGA_ADDR = {SIGA_IDX[13:0], 2'h0};
  localparam logic [15:0] STAT_ADDR = {STAT_IDX[13:0], 2'h0};

  // ==========================================================
  // reset values and field positions
  localparam logic [7:0] LIC_RST = 8'h00;
  localparam logic [7:0] FSEL_RST = 8'h00;
  localparam int LIC_ENC_BIT = 1;
  localparam int LIC_DEC_BIT = 0;
  localparam int STAT_ALIGN_BIT = 0;
  localparam int STAT_WIN_LSB = 1;
  localparam logic [2:0] MODE_ESF = 3'h0;

  // ==========================================================
  // crc-6, x^6 + x + 1
  localparam logic [5:0] CRC_POLY = 6'h03;
  localparam logic [5:0] CRC_SEED = 6'h00;
  localparam logic [5:0] CRC_FORCE_MASK = 6'h3f;

  // ==========================================================
  // types
  typedef struct packed {
    logic sig_sf;
    logic force_crc;
    logic japan_variant_select;
    logic single_candidate_only;
    logic fast_sync;
    logic [2:0] frame_mode;
  } tlc_fsel_t;

  typedef enum logic [1:0] {
    SYM_ZERO = 2'h0,
    SYM_MARK = 2'h1,
    SYM_POS = 2'h2,
    SYM_NEG = 2'h3
  } tlc_sym_t;

  typedef enum logic [1:0] {
    YEL_T1_SF = 2'h0,
    YEL_T1_ESF = 2'h1,
    YEL_J1_SF = 2'h2,
    YEL_J1_ESF = 2'h3
  } tlc_yel_t;

  typedef enum logic {
    SYNC_HUNT = 1'h0,
    SYNC_LOCK = 1'h1
  } tlc_sync_t;

endpackage : tlc_pkg

/* verif/tlc_remote_term.sv */
// tlc_remote_term: remote line terminal that sends b8zs-coded ami toward the block.
// assumes one bit strobe at a time from the bench and the single framer clock.
`timescale 1ns/1ns
module tlc_remote_term (
  input wire logic clk,
  input wire logic resetn,
  input wire logic bit_stb,
  input wire logic bit_in,
  output logic line_valid,
  output logic line_pos,
  output logic line_neg
);
  // ==========================================================
  // eight-deep symbol queue, substitution rewritten in place
  logic [1:0] q [8];
  logic last_pos;
  int zrun;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      line_valid <= 1'b0;
      line_pos <= 1'b0;
      line_neg <= 1'b0;
      last_pos = 1'b0;
      zrun = 0;
      foreach (q[i]) q[i] = 2'h0;
    end else if (bit_stb) begin
      line_valid <= 1'b1;
      {line_pos, line_neg} <= q[7];
      for (int i = 7; i > 0; i--) q[i] = q[i-1];
      q[0] = 2'h0;
      zrun++;
      if (bit_in) begin
        last_pos = !last_pos;
        q[0] = last_pos ? 2'h2 : 2'h1;
        zrun = 0;
      end else if (zrun == 8) begin
        // eight zeros leave as 000VB0VB around the last mark's polarity
        q[4] = last_pos ? 2'h2 : 2'h1;
        q[1] = q[4];
        q[3] = ~q[4];
        q[0] = q[3];
        // the closing b is opposite the last mark, so the next mark alternates from it
        last_pos = !last_pos;
        zrun = 0;
      end
    end else begin
      // released rails flip to the inverse each idle cycle, so an even idle run shows the stale symbol
      line_valid <= 1'b0;
      {line_pos, line_neg} <= ~{line_pos, line_neg};
    end
  end
endmodule : tlc_remote_term

/* verif/t1_line_code_and_framing_options_tb.sv */
// testbench for tlc_line_code: apb register access, line coding, signaling, crc, yellow, sync.
// assumes the remote terminal model on the receive rails and a 250 mhz clock.
`timescale 1ns/1ns
module t1_line_code_and_framing_options_tb;
  logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err, b;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, r, seed = 32'h0001_49f4;
  logic tx_frame_start = 1'b0, tx_valid = 1'b0, tx_bit = 1'b0, tx_pos, tx_neg, bit_stb = 1'b0, bit_in = 1'b0;
  logic rx_frame_start = 1'b0, rx_valid, rx_pos, rx_neg, rx_data, rx_data_valid;
  logic rx_sig_valid = 1'b0, rx_sf_boundary = 1'b0, tx_sf_boundary = 1'b0;
  logic [3:0] rx_sig_in = 4'h0, tx_sig_in = 4'h0, receive_signaling_out, tx_sig_out, v = 4'h0, w = 4'h0, ov, ow;
  logic crc_bit_valid = 1'b0, crc_bit = 1'b0, crc_fe = 1'b0, crc_mf_end = 1'b0;
  logic [5:0] crc_result, crc_exp;
  logic [1:0] tx_yellow_format, rx_yellow_format;
  logic search_done = 1'b0, sync_loss = 1'b0, frame_aligned;
  logic [7:0] cand_mask = 8'h00, m;
  logic [2:0] align_winner, md;
  logic [1:0] txs[$], rxs[$];
  logic [1:0] e_b8zs[$] = '{1, 0, 0, 0, 1, 2, 0, 1, 2, 1, 2};
  logic [1:0] e_ami[$] = '{1, 0, 0, 0, 0, 0, 0, 0, 0, 2, 1};
  logic [1:0] e_dec[$] = '{1, 0, 0, 0, 0, 0, 0, 0, 0, 1, 1};
  logic [1:0] e_raw[$] = '{1, 0, 0, 0, 1, 1, 0, 1, 1, 1, 1};
  int bad_count = 0, checked = 0;

  always #2 clk = ~clk;

  tlc_line_code DUT (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .tx_frame_start, .tx_valid, .tx_bit, .tx_pos, .tx_neg, .rx_frame_start, .rx_valid, .rx_pos, .rx_neg,
    .rx_data, .rx_data_valid, .rx_sig_valid, .rx_sig_in, .rx_sf_boundary, .receive_signaling_out,
    .tx_sig_in, .tx_sf_boundary, .tx_sig_out, .crc_bit_valid, .crc_bit, .crc_fe, .crc_mf_end, .crc_result,
    .tx_yellow_format, .rx_yellow_format, .search_done, .cand_mask, .sync_loss, .frame_aligned, .align_winner);

  tlc_remote_term partner (.clk(clk), .resetn(resetn), .bit_stb(bit_stb), .bit_in(bit_in),
    .line_valid(rx_valid), .line_pos(rx_pos), .line_neg(rx_neg));

  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // polarity-free search: the sign of a window's first mark depends on the traffic before it
  function automatic bit has_seq(logic [1:0] o[$], logic [1:0] e[$]);
    bit ok;
    for (int i = 0; i + e.size() <= o.size(); i++) begin
      for (int p = 0; p < 2; p++) begin
        ok = 1'b1;
        foreach (e[j]) if (o[i+j] !== ((e[j] == 2'h0) ? 2'h0 : (((e[j] == 2'h1) ^ p[0]) ? 2'h2 : 2'h1))) ok = 1'b0;
        if (ok) return 1'b1;
      end
    end
    return 1'b0;
  endfunction : has_seq

  function automatic logic [2:0] low(input logic [7:0] mk);
    logic [2:0] l;
    l = 3'h0;
    for (int i = 7; i >= 0; i--) if (mk[i]) l = 3'(i);
    return l;
  endfunction : low

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    if (bad_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // options load only at a frame start, so every change is followed by one
  task automatic cfg(input logic [7:0] f);
    apb(1'b1, tlc_pkg::FSEL_ADDR, {24'h0, f});
    @(posedge clk);
    tx_frame_start <= 1'b1;
    rx_frame_start <= 1'b1;
    @(posedge clk);
    tx_frame_start <= 1'b0;
    rx_frame_start <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask : cfg

  task automatic step(input logic bt);
    @(posedge clk);
    tx_valid <= 1'b1;
    tx_bit <= bt;
    bit_stb <= 1'b1;
    bit_in <= bt;
    @(posedge clk);
    tx_valid <= 1'b0;
    bit_stb <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    txs.push_back({tx_pos, tx_neg});
    if (rx_data_valid === 1'b1) rxs.push_back({rx_data, 1'b0});
  endtask : step

  task automatic sync_try(input logic one, input logic [7:0] mk, input logic exp_al);
    cfg({3'h0, one, 4'h0});
    @(posedge clk);
    sync_loss <= 1'b1;
    @(posedge clk);
    sync_loss <= 1'b0;
    @(negedge clk);
    chk("aligned_after_loss", frame_aligned, 32'h0);
    @(posedge clk);
    search_done <= 1'b1;
    cand_mask <= mk;
    @(posedge clk);
    search_done <= 1'b0;
    @(negedge clk);
    chk("aligned", frame_aligned, exp_al);
    if (exp_al) chk("winner", align_winner, low(mk));
    apb(1'b0, tlc_pkg::STAT_ADDR, 32'h0);
    chk("status_aligned", rd[0], exp_al);
  endtask : sync_try

  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, tlc_pkg::LIC_ADDR, 32'h0);
    chk("lic_reset", rd, {24'h0, tlc_pkg::LIC_RST});
    apb(1'b0, tlc_pkg::FSEL_ADDR, 32'h0);
    chk("fsel_reset", rd, {24'h0, tlc_pkg::FSEL_RST});
    apb(1'b0, 16'h0ffc, 32'h0);
    chk("unmapped_err", err, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    apb(1'b1, tlc_pkg::SIGA_ADDR, 32'h0000_000f);
    chk("read_only_err", err, 32'h1);
    r = rnd();
    apb(1'b1, tlc_pkg::LIC_ADDR, r);
    apb(1'b0, tlc_pkg::LIC_ADDR, 32'h0);
    chk("lic_rw", rd, {24'h0, r[7:0]});
    r = rnd();
    apb(1'b1, tlc_pkg::FSEL_ADDR, r);
    apb(1'b0, tlc_pkg::FSEL_ADDR, 32'h0);
    chk("fsel_rw", rd, {24'h0, r[7:0]});
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, tlc_pkg::LIC_ADDR, 32'(c));
      cfg(8'h00);
      txs.delete();
      rxs.delete();
      // a bit reaches rx_data sixteen strobes after it is sent: eight at the far end, eight here
      for (int k = 0; k < 32; k++) step(!(k >= 4 && k <= 11));
      chk("tx_rails", c[1] ? has_seq(txs, e_ami) : has_seq(txs, e_b8zs), 32'h1);
      chk("rx_bits", c[0] ? has_seq(rxs, e_raw) : has_seq(rxs, e_dec), 32'h1);
    end
    for (int s = 0; s < 2; s++) begin
      cfg({s[0], 7'h00});
      ov = v;
      ow = w;
      v = v ^ 4'(1 + rnd() % 15);
      w = w ^ 4'(1 + rnd() % 15);
      @(posedge clk);
      rx_sig_in <= v;
      rx_sig_valid <= 1'b1;
      tx_sig_in <= w;
      @(posedge clk);
      rx_sig_valid <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("rx_sig_hold", receive_signaling_out, s ? ov : v);
      chk("tx_sig_hold", tx_sig_out, s ? ow : w);
      @(posedge clk);
      rx_sf_boundary <= 1'b1;
      tx_sf_boundary <= 1'b1;
      @(posedge clk);
      rx_sf_boundary <= 1'b0;
      tx_sf_boundary <= 1'b0;
      @(negedge clk);
      chk("rx_sig", receive_signaling_out, v);
      chk("tx_sig", tx_sig_out, w);
      apb(1'b0, tlc_pkg::SIGA_ADDR, 32'h0);
      chk("sig_array", rd, v);
    end
    for (int c = 0; c < 4; c++) begin
      md = c[1] ? 3'(1 + rnd() % 7) : 3'h0;
      cfg({1'b0, c[1], c[0], 2'h0, md});
      chk("tx_yellow", tx_yellow_format, {c[0], md == 3'h0});
      chk("rx_yellow", rx_yellow_format, {c[0], md == 3'h0});
      crc_exp = tlc_pkg::CRC_SEED;
      for (int k = 0; k < 24; k++) begin
        r = rnd();
        @(posedge clk);
        crc_bit_valid <= 1'b1;
        crc_bit <= r[0];
        crc_fe <= r[1];
        crc_mf_end <= (k == 23);
        b = (r[1] && !c[0]) ? 1'b1 : r[0];
        crc_exp = {crc_exp[4:0], 1'b0} ^ ((crc_exp[5] ^ b) ? tlc_pkg::CRC_POLY : 6'h00);
      end
      @(posedge clk);
      crc_bit_valid <= 1'b0;
      crc_mf_end <= 1'b0;
      @(negedge clk);
      chk("crc", crc_result, crc_exp ^ (c[1] ? tlc_pkg::CRC_FORCE_MASK : 6'h00));
    end
    r = rnd();
    m = 8'h80 | (8'h01 << (r % 7)) | (r[15:8] & 8'h7f);
    sync_try(1'b0, m, 1'b1);
    sync_try(1'b1, m, 1'b0);
    sync_try(1'b1, 8'h01 << r[18:16], 1'b1);
    conclude();
  end

  // watchdog: the whole run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude();
  end
endmodule : t1_line_code_and_framing_options_tb
